// [include/ais_pkg.sv]
// shared constants and types for the analog input scaling block
package ais_pkg;

    // channel count, reported read-only in each object group
    localparam int NCH = 32'h0000_0002;
    localparam logic [7:0] CH_COUNT = 8'h02;

    // converter code: 1024 counts, voltage mode puts zero volts mid-scale
    localparam int ADC_W = 32'h0000_000A;
    localparam int ADC_SPAN = 32'h0000_0400;
    localparam int ADC_MID = 32'h0000_0200;

    // object dictionary indices and subindices
    localparam logic [15:0] IDX_VALUE = 16'h3320;
    localparam logic [15:0] IDX_OFFSET = 16'h3321;
    localparam logic [15:0] IDX_DIVISOR = 16'h3322;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_CH1 = 8'h01;
    localparam logic [7:0] SUB_CH2 = 8'h02;

    // values after reset
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
    localparam logic [31:0] DIVISOR_RST = 32'h0000_0001;
    localparam logic [31:0] VALUE_RST = 32'h0000_0000;

    // divider: one quotient bit per cycle, last step index
    localparam logic [4:0] DIV_LAST = 5'h1F;

    // conversion sequencer, gray along idle-wait-store-next
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_STORE = 2'h3,
        ST_NEXT = 2'h2
    } ais_state_t;

    // object access request, one cycle strobe in sel
    typedef struct packed {
        logic sel;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } ais_req_t;

    // object access answer, ack is a one cycle pulse
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } ais_rsp_t;

endpackage : ais_pkg

// [rtl/ais_divider.sv]
// iterative signed divider, quotient truncated toward zero
`timescale 1ns/1ps
module ais_divider (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic signed [31:0] dividend,
    input wire logic signed [31:0] divisor,
    output logic busy_r,
    output logic done_r,
    output logic signed [31:0] quot_r
);
    logic [31:0] mag_r, mag_nxt, dvs_r, dvs_nxt;
    logic [32:0] rem_r, rem_nxt, shifted;
    logic [4:0] cnt_r, cnt_nxt;
    logic neg_r, neg_nxt, busy_nxt, done_nxt, fit;
    logic signed [31:0] quot_nxt;

    // restoring division on magnitudes, sign applied at the end
    always_comb begin
        mag_nxt = mag_r;
        dvs_nxt = dvs_r;
        rem_nxt = rem_r;
        cnt_nxt = cnt_r;
        neg_nxt = neg_r;
        busy_nxt = busy_r;
        quot_nxt = quot_r;
        done_nxt = 1'b0;
        shifted = {rem_r[31:0], mag_r[31]};
        fit = shifted >= {1'b0, dvs_r};
        if (start && !busy_r) begin
            // negating the most negative value still gives its magnitude
            mag_nxt = dividend[31] ? 32'(-dividend) : dividend;
            dvs_nxt = divisor[31] ? 32'(-divisor) : divisor;
            rem_nxt = 33'h0_0000_0000;
            neg_nxt = dividend[31] ^ divisor[31]; // see R10
            cnt_nxt = 5'h00;
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            rem_nxt = fit ? 33'(shifted - {1'b0, dvs_r}) : shifted;
            mag_nxt = {mag_r[30:0], fit};
            cnt_nxt = 5'(cnt_r + 5'h01);
            if (cnt_r == ais_pkg::DIV_LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                quot_nxt = neg_r ? 32'(-{mag_r[30:0], fit})
                                 : {mag_r[30:0], fit}; // see R4
            end
        end
    end

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mag_r <= 32'h0000_0000;
            dvs_r <= 32'h0000_0000;
            rem_r <= 33'h0_0000_0000;
            cnt_r <= 5'h00;
            neg_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            quot_r <= 32'h0000_0000;
        end else begin
            mag_r <= mag_nxt;
            dvs_r <= dvs_nxt;
            rem_r <= rem_nxt;
            cnt_r <= cnt_nxt;
            neg_r <= neg_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            quot_r <= quot_nxt;
        end
    end

    // operands kept only for checking the result
    logic signed [31:0] chk_dvd_r, chk_dvs_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chk_dvd_r <= 32'h0000_0000;
            chk_dvs_r <= 32'h0000_0001;
        end else if (start && !busy_r) begin
            chk_dvd_r <= dividend;
            chk_dvs_r <= divisor;
        end
    end

    default clocking dcb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_div_latency: assert property (start && !busy_r |-> ##33 done_r) // see R4
        else $error("divider result not ready 33 cycles after start");
    a_div_truncate: assert property ( // see R10
        done_r && chk_dvs_r != 32'h0000_0000 &&
        !(chk_dvs_r == 32'hFFFF_FFFF && chk_dvd_r == 32'h8000_0000)
        |-> quot_r == chk_dvd_r / chk_dvs_r)
        else $error("quotient not truncated toward zero");
    c_div_negative: cover property (done_r && quot_r < 0);

endmodule : ais_divider

// [rtl/ais_scaler.sv]
// two-channel analog input scaler with offset and divisor objects
`timescale 1ns/1ps
// Summary of operation
// R1 - Two channels exist and each object group reports 2 in a read-only subindex 0.
// R2 - Each channel's scaled value is kept current and read as a signed 32-bit word.
// R3 - The channel offset is added to the raw code before dividing.
// R4 - The corrected reading is divided by the channel divisor and the quotient stored.
// R5 - Software must never program a zero divisor; any other value is allowed.
// R6 - Reset leaves offsets at 0 and divisors at 1, so values equal the raw code.
// R7 - Raw codes span 1024 counts, mid-scale is 0 V in voltage mode, 0 is 0 mA.
// R8 - Each channel has its own writable signed offset used only for that channel.
// R9 - Each channel has its own writable signed divisor used only for that channel.
// R10 - Division truncates toward zero and a zero divisor keeps the old value.
module ais_scaler (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic adc_valid,
    input wire logic [ais_pkg::NCH-1:0][ais_pkg::ADC_W-1:0] adc_code,
    input wire ais_pkg::ais_req_t obj_req,
    output ais_pkg::ais_rsp_t obj_rsp_r,
    output logic [ais_pkg::NCH-1:0][31:0] scaled_val_r
);
    logic [ais_pkg::ADC_W-1:0] raw_r [ais_pkg::NCH];
    logic [ais_pkg::ADC_W-1:0] raw_nxt [ais_pkg::NCH];
    logic [ais_pkg::NCH-1:0][31:0] off_r, off_nxt, dvs_r, dvs_nxt, val_nxt;
    ais_pkg::ais_rsp_t rsp_nxt;
    ais_pkg::ais_state_t st_r, st_nxt;
    logic ch_r, ch_nxt;
    logic div_start, div_busy, div_done;
    logic signed [31:0] dividend, div_quot;
    logic known_idx, known_sub, req_ch;

    // subindex 1 or 2 addresses a channel
    function automatic logic sub_is_ch(input logic [7:0] sub);
        return sub == ais_pkg::SUB_CH1 || sub == ais_pkg::SUB_CH2;
    endfunction : sub_is_ch

    // channel number addressed by a channel subindex
    function automatic logic sub_ch(input logic [7:0] sub);
        return sub == ais_pkg::SUB_CH2;
    endfunction : sub_ch

    // raw code capture per channel, same clock as the converter
    for (genvar g = 0; g < ais_pkg::NCH; g++) begin : g_raw
        always_comb begin
            raw_nxt[g] = raw_r[g];
            if (adc_valid) begin
                raw_nxt[g] = adc_code[g];
            end
        end
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                raw_r[g] <= '0;
            end else begin
                raw_r[g] <= raw_nxt[g];
            end
        end
    end

    // raw code is unsigned counts, mode interpretation is left to software
    assign dividend = $signed({{(32 - ais_pkg::ADC_W){1'b0}}, raw_r[ch_r]})
                    + $signed(off_r[ch_r]); // see R7 see R3 see R8

    ais_divider u_div (
        .clk(clk),
        .arst_n(arst_n),
        .start(div_start),
        .dividend(dividend),
        .divisor(dvs_r[ch_r]),
        .busy_r(div_busy),
        .done_r(div_done),
        .quot_r(div_quot)
    );

    // sequencer alternates channels; one conversion takes 36 cycles
    always_comb begin
        st_nxt = st_r;
        ch_nxt = ch_r;
        val_nxt = scaled_val_r;
        div_start = 1'b0;
        case (st_r)
            ais_pkg::ST_IDLE: begin
                // a zero divisor is skipped so the old value stays
                if (dvs_r[ch_r] != 32'h0000_0000) begin // see R5 see R10
                    div_start = 1'b1;
                    st_nxt = ais_pkg::ST_WAIT;
                end else begin
                    st_nxt = ais_pkg::ST_NEXT;
                end
            end
            ais_pkg::ST_WAIT: begin
                if (div_done) begin
                    st_nxt = ais_pkg::ST_STORE;
                end
            end
            ais_pkg::ST_STORE: begin
                val_nxt[ch_r] = div_quot; // see R4 see R2 see R9
                st_nxt = ais_pkg::ST_NEXT;
            end
            ais_pkg::ST_NEXT: begin
                ch_nxt = ~ch_r;
                st_nxt = ais_pkg::ST_IDLE;
            end
            default: begin
                st_nxt = ais_pkg::ST_IDLE;
            end
        endcase
    end

    // object access decode
    assign known_idx = obj_req.index == ais_pkg::IDX_VALUE
                    || obj_req.index == ais_pkg::IDX_OFFSET
                    || obj_req.index == ais_pkg::IDX_DIVISOR;
    assign known_sub = obj_req.sub == ais_pkg::SUB_COUNT
                    || sub_is_ch(obj_req.sub);
    assign req_ch = sub_ch(obj_req.sub);

    // object reads and writes, answered one cycle after the request
    always_comb begin
        off_nxt = off_r;
        dvs_nxt = dvs_r;
        rsp_nxt = '0;
        if (obj_req.sel) begin
            rsp_nxt.ack = 1'b1;
            if (!known_idx || !known_sub) begin
                rsp_nxt.err = 1'b1;
            end else if (obj_req.wr) begin
                // count entries and scaled values are read-only
                if (!sub_is_ch(obj_req.sub)
                    || obj_req.index == ais_pkg::IDX_VALUE) begin // see R2
                    rsp_nxt.err = 1'b1;
                end else if (obj_req.index == ais_pkg::IDX_OFFSET) begin
                    off_nxt[req_ch] = obj_req.wdata; // see R8
                end else begin
                    // zero is stored as written; conversion then holds
                    dvs_nxt[req_ch] = obj_req.wdata; // see R9
                end
            end else if (obj_req.sub == ais_pkg::SUB_COUNT) begin
                rsp_nxt.rdata = {24'h00_0000, ais_pkg::CH_COUNT}; // see R1
            end else if (obj_req.index == ais_pkg::IDX_VALUE) begin
                rsp_nxt.rdata = scaled_val_r[req_ch]; // see R2
            end else if (obj_req.index == ais_pkg::IDX_OFFSET) begin
                rsp_nxt.rdata = off_r[req_ch];
            end else begin
                rsp_nxt.rdata = dvs_r[req_ch];
            end
        end
    end

    // registers; presets give value equal to raw code
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ais_pkg::ST_IDLE;
            ch_r <= 1'b0;
            off_r <= {ais_pkg::NCH{ais_pkg::OFFSET_RST}}; // see R6
            dvs_r <= {ais_pkg::NCH{ais_pkg::DIVISOR_RST}}; // see R6
            scaled_val_r <= {ais_pkg::NCH{ais_pkg::VALUE_RST}};
            obj_rsp_r <= '0;
        end else begin
            st_r <= st_nxt;
            ch_r <= ch_nxt;
            off_r <= off_nxt;
            dvs_r <= dvs_nxt;
            scaled_val_r <= val_nxt;
            obj_rsp_r <= rsp_nxt;
        end
    end

    // marks the first cycle after reset release, for checking only
    logic seen_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seen_r <= 1'b0;
        end else begin
            seen_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_count_read: assert property ( // see R1
        obj_req.sel && !obj_req.wr && known_idx
        && obj_req.sub == ais_pkg::SUB_COUNT
        |=> obj_rsp_r.ack && !obj_rsp_r.err
        && obj_rsp_r.rdata == 32'h0000_0002)
        else $error("count entry did not read as two");
    a_value_ro: assert property ( // see R2
        obj_req.sel && obj_req.wr && obj_req.index == ais_pkg::IDX_VALUE
        |=> obj_rsp_r.ack && obj_rsp_r.err)
        else $error("write to scaled value was not refused");
    a_offset_sum: assert property ( // see R3
        div_start |-> 32'(dividend - $signed(off_r[ch_r]))
        == {{(32 - ais_pkg::ADC_W){1'b0}}, raw_r[ch_r]})
        else $error("dividend is not raw code plus offset");
    a_div_turnaround: assert property ( // see R4
        div_start |-> ##33 (div_done && st_r == ais_pkg::ST_WAIT)
        ##1 st_r == ais_pkg::ST_STORE)
        else $error("division did not complete in 33 cycles");
    a_store_quot: assert property ( // see R4
        st_r == ais_pkg::ST_STORE
        |=> scaled_val_r[ch_r] == $past(div_quot)
        && scaled_val_r[~ch_r] == $past(scaled_val_r[~ch_r]))
        else $error("quotient not stored to its own channel");
    a_reset_presets: assert property ( // see R6
        !seen_r |-> off_r == {ais_pkg::NCH{32'h0000_0000}}
        && dvs_r == {ais_pkg::NCH{32'h0000_0001}})
        else $error("offset or divisor presets wrong after reset");
    a_offset_write: assert property ( // see R8
        obj_req.sel && obj_req.wr && obj_req.index == ais_pkg::IDX_OFFSET
        && obj_req.sub == ais_pkg::SUB_CH1
        |=> off_r[0] == $past(obj_req.wdata) && $stable(off_r[1]))
        else $error("offset write did not reach channel one only");
    a_divisor_write: assert property ( // see R9
        obj_req.sel && obj_req.wr && obj_req.index == ais_pkg::IDX_DIVISOR
        && obj_req.sub == ais_pkg::SUB_CH2
        |=> dvs_r[1] == $past(obj_req.wdata) && $stable(dvs_r[0]))
        else $error("divisor write did not reach channel two only");
    a_zero_hold: assert property ( // see R10
        st_r == ais_pkg::ST_IDLE && dvs_r[ch_r] == 32'h0000_0000
        |-> !div_start ##1 $stable(scaled_val_r) [*2])
        else $error("value changed although divisor is zero");

    // refused places answer with err and no data
    a_bad_place: assert property ( // see R1
        obj_req.sel && (!known_idx || !known_sub)
        |=> obj_rsp_r.ack && obj_rsp_r.err
        && obj_rsp_r.rdata == 32'h0000_0000)
        else $error("unknown object place was not refused");

    // a refused write must leave every setting untouched
    a_refused_keeps: assert property ( // see R8
        obj_req.sel && obj_req.wr
        && (!known_idx || !known_sub || obj_req.sub == ais_pkg::SUB_COUNT
        || obj_req.index == ais_pkg::IDX_VALUE)
        |=> $stable(off_r) && $stable(dvs_r))
        else $error("refused write changed a setting");

    // no answer appears without a request the cycle before
    a_ack_only_req: assert property ( // see R2
        !obj_req.sel
        |=> !obj_rsp_r.ack && obj_rsp_r.rdata == 32'h0000_0000)
        else $error("answer without a request");

    // value reads return the stored quotient of the addressed channel
    a_value_read: assert property ( // see R2
        obj_req.sel && !obj_req.wr && obj_req.index == ais_pkg::IDX_VALUE
        && sub_is_ch(obj_req.sub)
        |=> obj_rsp_r.rdata == $past(scaled_val_r[req_ch]))
        else $error("value read returned the wrong channel");

    // offset reads return the setting of the addressed channel
    a_offset_read: assert property ( // see R8
        obj_req.sel && !obj_req.wr && obj_req.index == ais_pkg::IDX_OFFSET
        && sub_is_ch(obj_req.sub)
        |=> obj_rsp_r.rdata == $past(off_r[req_ch]))
        else $error("offset read returned the wrong channel");

    // divisor reads return the setting of the addressed channel
    a_divisor_read: assert property ( // see R9
        obj_req.sel && !obj_req.wr && obj_req.index == ais_pkg::IDX_DIVISOR
        && sub_is_ch(obj_req.sub)
        |=> obj_rsp_r.rdata == $past(dvs_r[req_ch]))
        else $error("divisor read returned the wrong channel");

    // each offset write reaches its own channel only
    a_offset_write_ch2: assert property ( // see R8
        obj_req.sel && obj_req.wr && obj_req.index == ais_pkg::IDX_OFFSET
        && obj_req.sub == ais_pkg::SUB_CH2
        |=> off_r[1] == $past(obj_req.wdata) && $stable(off_r[0]))
        else $error("offset write did not reach channel two only");

    // each divisor write reaches its own channel only
    a_divisor_write_ch1: assert property ( // see R9
        obj_req.sel && obj_req.wr && obj_req.index == ais_pkg::IDX_DIVISOR
        && obj_req.sub == ais_pkg::SUB_CH1
        |=> dvs_r[0] == $past(obj_req.wdata) && $stable(dvs_r[1]))
        else $error("divisor write did not reach channel one only");

    // converter codes are taken only on the valid strobe
    a_raw_capture: assert property ( // see R7
        adc_valid |=> raw_r[0] == $past(adc_code[0])
        && raw_r[1] == $past(adc_code[1]))
        else $error("converter code not captured on strobe");

    a_raw_hold: assert property ( // see R7
        !adc_valid |=> raw_r[0] == $past(raw_r[0])
        && raw_r[1] == $past(raw_r[1]))
        else $error("raw code moved without a strobe");

    // channels alternate after every visit, stored or skipped
    a_ch_alternate: assert property ( // see R2
        st_r == ais_pkg::ST_NEXT
        |=> st_r == ais_pkg::ST_IDLE && ch_r != $past(ch_r))
        else $error("sequencer did not move to the other channel");

    // presented values move only in the store state
    a_value_only_store: assert property ( // see R4
        st_r != ais_pkg::ST_STORE |=> $stable(scaled_val_r))
        else $error("value changed outside the store state");

    // a zero divisor write is taken, the channel then just holds
    a_zero_accept: assert property ( // see R10
        obj_req.sel && obj_req.wr && obj_req.index == ais_pkg::IDX_DIVISOR
        && sub_is_ch(obj_req.sub) && obj_req.wdata == 32'h0000_0000
        |=> !obj_rsp_r.err && dvs_r[$past(req_ch)] == 32'h0000_0000)
        else $error("zero divisor write was refused");

    c_store_ch1: cover property (st_r == ais_pkg::ST_STORE && !ch_r);
    c_store_ch2: cover property (st_r == ais_pkg::ST_STORE && ch_r);
    c_zero_skip: cover property (
        st_r == ais_pkg::ST_IDLE && dvs_r[ch_r] == 32'h0000_0000);
    c_bad_access: cover property (obj_rsp_r.ack && obj_rsp_r.err);

endmodule : ais_scaler

// [test/ais_adc_model.sv]
// behavioural converter model feeding two raw channel codes
`timescale 1ns/1ps
module ais_adc_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] period,
    input wire logic [1:0][9:0] code_in,
    output logic adc_valid,
    output logic [1:0][9:0] adc_code
);
    logic [7:0] cnt_r;
    logic [1:0][9:0] last_r;

    // one sample each period+1 cycles; a long period models a slow converter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 8'h00;
            adc_valid <= 1'b0;
            adc_code <= '0;
            last_r <= '0;
        end else if (cnt_r >= period) begin
            cnt_r <= 8'h00;
            adc_valid <= 1'b1;
            adc_code <= code_in; // 10-bit codes, 1024 counts
            last_r <= code_in;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            adc_valid <= 1'b0;
            adc_code <= ~last_r; // lines not held outside the strobe
        end
    end
endmodule : ais_adc_model

// [test/tb_ais_scaler.sv]
// self-checking bench for the analog input scaler
`timescale 1ns/1ps
module tb_ais_scaler;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic adc_valid;
    logic [1:0][9:0] adc_code;
    logic [1:0][9:0] code_in = '0;
    logic [7:0] period = 8'h03;
    ais_pkg::ais_req_t obj_req = '0;
    ais_pkg::ais_rsp_t obj_rsp_r;
    logic [1:0][31:0] scaled_val_r;
    logic [31:0] exp_v [2];
    logic [31:0] r [6];
    logic [31:0] rd;
    logic er;
    integer seed = 32'hace3;
    int errors = 0;
    int n_compared = 0;

    // 125 MHz clock
    always #4 clk = ~clk;

    ais_scaler u_dut (.clk(clk), .arst_n(arst_n), .adc_valid(adc_valid),
        .adc_code(adc_code), .obj_req(obj_req), .obj_rsp_r(obj_rsp_r),
        .scaled_val_r(scaled_val_r));

    ais_adc_model u_adc (.clk(clk), .arst_n(arst_n), .period(period),
        .code_in(code_in), .adc_valid(adc_valid), .adc_code(adc_code));

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one object access; request dropped at the taking edge
    task automatic obj(input logic wr, input logic [15:0] idx,
                       input logic [7:0] sub, input logic [31:0] wd);
        int n;
        @(posedge clk);
        obj_req <= '{sel: 1'b1, wr: wr, index: idx, sub: sub, wdata: wd};
        @(posedge clk);
        obj_req.sel <= 1'b0;
        n = 0;
        #1;
        while (obj_rsp_r.ack !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (obj_rsp_r.ack !== 1'b1) begin
            errors++;
            $display("[ERR] %0t no answer on object bus", $time);
            report_and_stop();
        end
        rd = obj_rsp_r.rdata;
        er = obj_rsp_r.err;
    endtask : obj

    // expected value: offset first, then signed divide toward zero
    function automatic logic [31:0] scale(input logic [9:0] raw,
        input logic [31:0] o, input logic [31:0] d, input logic [31:0] prev);
        logic signed [31:0] s;
        s = $signed({22'h00_0000, raw} + o);
        if (d == 32'h0000_0000)
            return prev;
        if (s == 32'h8000_0000 && d == 32'hFFFF_FFFF)
            return s;
        return s / $signed(d);
    endfunction : scale

    // program both channels, let two refresh rounds pass, compare
    task automatic run_case(input logic [9:0] c0, input logic [9:0] c1,
        input logic [31:0] o0, input logic [31:0] o1,
        input logic [31:0] d0, input logic [31:0] d1);
        // divisors first, so a zero divisor freezes the old settings' value
        obj(1'b1, ais_pkg::IDX_DIVISOR, ais_pkg::SUB_CH1, d0);
        obj(1'b1, ais_pkg::IDX_DIVISOR, ais_pkg::SUB_CH2, d1);
        obj(1'b1, ais_pkg::IDX_OFFSET, ais_pkg::SUB_CH1, o0);
        obj(1'b1, ais_pkg::IDX_OFFSET, ais_pkg::SUB_CH2, o1);
        code_in <= {c1, c0};
        repeat (160) @(posedge clk);
        exp_v[0] = scale(c0, o0, d0, exp_v[0]);
        exp_v[1] = scale(c1, o1, d1, exp_v[1]);
        chk(scaled_val_r[0], exp_v[0], "ch1 value");
        chk(scaled_val_r[1], exp_v[1], "ch2 value");
        obj(1'b0, ais_pkg::IDX_VALUE, ais_pkg::SUB_CH2, 32'h0000_0000);
        chk(rd, exp_v[1], "ch2 value read");
    endtask : run_case

    initial begin
        exp_v = '{32'h0000_0000, 32'h0000_0000};
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        #1;
        chk(scaled_val_r[0], ais_pkg::VALUE_RST, "value after reset");
        chk(scaled_val_r[1], ais_pkg::VALUE_RST, "ch2 after reset");
        for (int i = 0; i < 3; i++) begin
            obj(1'b0, ais_pkg::IDX_VALUE + 16'(i), ais_pkg::SUB_COUNT,
                32'h0000_0000);
            chk(rd, 32'h0000_0002, "channel count");
        end
        for (int i = 1; i < 3; i++) begin
            obj(1'b0, ais_pkg::IDX_OFFSET, 8'(i), 32'h0000_0000);
            chk(rd, ais_pkg::OFFSET_RST, "offset preset");
            obj(1'b0, ais_pkg::IDX_DIVISOR, 8'(i), 32'h0000_0000);
            chk(rd, ais_pkg::DIVISOR_RST, "divisor preset");
        end
        $display("test presets done");
        // read-only entries and unknown places are refused
        obj(1'b1, ais_pkg::IDX_VALUE, ais_pkg::SUB_CH1, 32'h0000_0055);
        chk({31'h0, er}, 32'h0000_0001, "value write refused");
        obj(1'b1, ais_pkg::IDX_OFFSET, ais_pkg::SUB_COUNT, 32'h0000_0007);
        chk({31'h0, er}, 32'h0000_0001, "count write refused");
        obj(1'b0, 16'h3323, ais_pkg::SUB_CH1, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000, "bad index");
        obj(1'b0, ais_pkg::IDX_DIVISOR, 8'h03, 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000, "bad subindex");
        obj(1'b0, ais_pkg::IDX_OFFSET, ais_pkg::SUB_COUNT, 32'h0000_0000);
        chk(rd, 32'h0000_0002, "count kept");
        $display("test refusals done");
        run_case(10'h3FF, 10'h000, 32'h0, 32'h0, 32'h1, 32'h1);
        run_case(10'h200, 10'h3FF, 32'hFFFF_FE00, 32'h0000_0005,
                 32'hFFFF_FFFD, 32'h0000_0007);
        run_case(10'h001, 10'h07B, 32'h7FFF_FFFF, 32'hFFFF_F000,
                 32'hFFFF_FFFF, 32'h0000_0004);
        period <= 8'h40;
        run_case(10'h155, 10'h2AA, 32'h0, 32'h0, 32'h0, 32'h2);
        $display("test corners done");
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 6; j++)
                r[j] = $random(seed);
            for (int j = 4; j < 6; j++) begin
                if (r[j][1])
                    r[j] = $signed(r[j]) >>> 26;
                if (r[j] == 32'h0000_0000)
                    r[j] = 32'h0000_0001; // nonzero only
            end
            period <= 8'(r[0][15:12]);
            run_case(r[0][9:0], r[1][9:0], r[2], r[3], r[4], r[5]);
        end
        $display("test random done");
        report_and_stop();
    end
endmodule : tb_ais_scaler
